// [logic/dasr_pkg.sv]
package dasr_pkg;
    // query opcodes
    localparam logic [15:0] OP_CURRENT = 16'h2409;
    localparam logic [15:0] OP_LATCHED = 16'h2406;
    localparam logic [15:0] OP_ASYNC   = 16'h2452;
    // response lengths in bytes
    localparam logic [3:0] LEN_CURRENT = 4'h9;
    localparam logic [3:0] LEN_LATCHED = 4'h8;
    localparam logic [3:0] LEN_ASYNC   = 4'h4;
    // implemented bit masks; every other position reads zero
    localparam logic [7:0] MASK_RX      = 8'hff;
    localparam logic [7:0] MASK_BUF     = 8'hff;
    localparam logic [7:0] MASK_LOCK    = 8'h7d;
    localparam logic [7:0] MASK_CLK     = 8'hff;
    localparam logic [7:0] MASK_INSERT  = 8'h07;
    localparam logic [7:0] MASK_SUPPLY  = 8'h07;
    localparam logic [7:0] MASK_SPARE   = 8'h00;
    localparam logic [7:0] MASK_DEC     = 8'h4d;
    localparam logic [7:0] MASK_LNB     = 8'h07;
    localparam logic [7:0] LMASK_CLK    = 8'hc0;
    localparam logic [7:0] LMASK_DEC    = 8'h44;
    localparam int         SUMMARY_BIT  = 7;
    // APB map
    localparam logic [7:0] ADDR_QUERY   = 8'h00;
    localparam logic [7:0] ADDR_STATUS  = 8'h04;
    localparam logic [7:0] ADDR_DATA    = 8'h08;
    localparam logic [7:0] ADDR_ASYNC   = 8'h0c;
    localparam logic [7:0] ADDR_CLEAR   = 8'h10;
    // async config register fields
    localparam int ASYNC_MODE_BIT = 0;
    localparam int ASYNC_TYPE_BIT = 1;
    localparam int ASYNC_BAUD_LO  = 2;
    localparam int ASYNC_DBIT_BIT = 5;
    localparam logic [5:0] ASYNC_RESET = 6'h38;
    typedef enum logic [1:0] {
        DASR_IDLE = 2'b00,
        DASR_CUR  = 2'b01,
        DASR_LAT  = 2'b10,
        DASR_ASY  = 2'b11
    } dasr_state_e;
endpackage

// [logic/dasr_core.sv]
// What this block does
// - current-alarm query returns nine bytes in fixed order
// - receive byte one bits 0-5 and 7 flag receive failures
// - receive byte one bit 6 shows receive data activity
// - buffer byte bits 0-3 flag underflow, overflow, under 10%, over 90%
// - buffer byte bits 4-7 flag decoder faults and summary fault
// - lock byte bits 0,2-6 show locks; bits 1 and 7 reserved
// - clock activity byte bits 0-5 show clock activity
// - clock byte bit 6 clock fallback, bit 7 low Eb/No
// - insert byte bits 0-2 frame, multiframe, CRC lock faults
// - supply byte bits 0-2 flag -12 V, +12 V, 5 V rails
// - decoder byte bits 0,2,3,6 trellis, signalling, turbo, DVB
// - lnb byte bits 0-2 LNB current, voltage, Ethernet WAN
// - latched query returns eight bytes in fixed order
// - latched summary fault bit follows live state
// - latched clock byte holds bits 6,7; decoder byte bits 2,6
// - async config returns mode, electrical type, baud and data bits bytes in that order
// - spare common byte is zero but occupies its slot
// - latched response only for the latched query code
//
// The APB interface to the registers and the placing of the registers were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
module dasr_core
    import dasr_pkg::*;
(
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        clk_en,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic [7:0]  receive_fault_byte_one,
    input  wire logic [7:0]  buffer_decoder_fault_byte,
    input  wire logic [7:0]  lock_indicator_byte,
    input  wire logic [7:0]  clock_activity_byte,
    input  wire logic [7:0]  insert_fault_byte,
    input  wire logic [7:0]  supply_rail_fault_byte,
    input  wire logic [7:0]  spare_common_byte,
    input  wire logic [7:0]  decoder_frame_fault_byte,
    input  wire logic [7:0]  lnb_ethernet_fault_byte
);
    localparam int NB = 9;
    logic [7:0] s1_r [NB];
    logic [7:0] live_r [NB];
    logic [7:0] raw [NB];
    logic [7:0] msk [NB];
    logic [7:0] lmsk [NB];
    logic [7:0] lat_r [NB];
    dasr_state_e state_r;
    logic [3:0]  idx_r;
    logic [5:0]  async_r;
    logic [7:0]  byte_out;
    logic [3:0]  len;
    logic        acc, wr, rd, mapped;

    always_comb begin
        raw[0] = receive_fault_byte_one;
        raw[1] = buffer_decoder_fault_byte;
        raw[2] = lock_indicator_byte;
        raw[3] = clock_activity_byte;
        raw[4] = insert_fault_byte;
        raw[5] = supply_rail_fault_byte;
        raw[6] = spare_common_byte;
        raw[7] = decoder_frame_fault_byte;
        raw[8] = lnb_ethernet_fault_byte;
        msk[0] = MASK_RX;
        msk[1] = MASK_BUF;
        msk[2] = MASK_LOCK;
        msk[3] = MASK_CLK;
        msk[4] = MASK_INSERT;
        msk[5] = MASK_SUPPLY;
        msk[6] = MASK_SPARE;
        msk[7] = MASK_DEC;
        msk[8] = MASK_LNB;
        for (int i = 0; i < NB; i++) begin
            lmsk[i] = msk[i];
        end
        lmsk[3] = LMASK_CLK;
        lmsk[7] = LMASK_DEC;
        lmsk[1] = MASK_BUF & ~(8'h01 << SUMMARY_BIT);
    end

    assign acc    = psel && penable && clk_en;
    // effects land only at the completing edge, so one data read steps one byte
    assign wr     = acc && pready && pwrite;
    assign rd     = acc && pready && !pwrite;
    assign mapped = (paddr == ADDR_QUERY) || (paddr == ADDR_STATUS) || (paddr == ADDR_DATA)
                 || (paddr == ADDR_ASYNC) || (paddr == ADDR_CLEAR);

    // alarm inputs come from other logic on unknown timing; two stages before use
    genvar g;
    generate
        for (g = 0; g < NB; g++) begin : g_byte
            always_ff @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    s1_r[g]   <= 8'h00;
                    live_r[g] <= 8'h00;
                end else if (clk_en) begin
                    s1_r[g]   <= raw[g];
                    live_r[g] <= s1_r[g] & msk[g];
                end
            end
            // set wins over a clear in the same cycle; reads never clear
            always_ff @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    lat_r[g] <= 8'h00;
                end else if (clk_en) begin
                    if (wr && paddr == ADDR_CLEAR && pwdata[g]) begin
                        lat_r[g] <= live_r[g] & lmsk[g];
                    end else begin
                        lat_r[g] <= lat_r[g] | (live_r[g] & lmsk[g]);
                    end
                end
            end
        end
    endgenerate

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            async_r <= ASYNC_RESET;
        end else if (wr && paddr == ADDR_ASYNC) begin
            async_r <= pwdata[5:0];
        end
    end

    always_comb begin
        case (state_r)
            DASR_CUR: len = LEN_CURRENT;
            DASR_LAT: len = LEN_LATCHED;
            DASR_ASY: len = LEN_ASYNC;
            default:  len = 4'h0;
        endcase
    end

    // response byte at the current index of the selected query
    always_comb begin
        byte_out = 8'h00;
        case (state_r)
            DASR_CUR: begin
                if (idx_r < LEN_CURRENT) begin
                    byte_out = live_r[idx_r];
                end
            end
            DASR_LAT: begin
                // order: rx, buf, lock, supply, spare, clk, dec, lnb
                case (idx_r)
                    4'h0: byte_out = lat_r[0];
                    4'h1: byte_out = {live_r[1][SUMMARY_BIT], lat_r[1][6:0]};
                    4'h2: byte_out = lat_r[2];
                    4'h3: byte_out = lat_r[5];
                    4'h4: byte_out = lat_r[6];
                    4'h5: byte_out = lat_r[3];
                    4'h6: byte_out = lat_r[7];
                    4'h7: byte_out = lat_r[8];
                    default: byte_out = 8'h00;
                endcase
            end
            DASR_ASY: begin
                case (idx_r)
                    4'h0: byte_out = {7'h00, async_r[ASYNC_MODE_BIT]};
                    4'h1: byte_out = {7'h00, async_r[ASYNC_TYPE_BIT]};
                    4'h2: byte_out = {5'h00, async_r[ASYNC_BAUD_LO +: 3]};
                    4'h3: byte_out = {7'h00, async_r[ASYNC_DBIT_BIT]};
                    default: byte_out = 8'h00;
                endcase
            end
            default: byte_out = 8'h00;
        endcase
    end

    // query write selects a response; each data read steps one byte
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_r <= DASR_IDLE;
            idx_r   <= 4'h0;
        end else if (wr && paddr == ADDR_QUERY) begin
            idx_r <= 4'h0;
            if (pwdata[15:0] == OP_CURRENT) begin
                state_r <= DASR_CUR;
            end else if (pwdata[15:0] == OP_LATCHED) begin
                state_r <= DASR_LAT;
            end else if (pwdata[15:0] == OP_ASYNC) begin
                state_r <= DASR_ASY;
            end else begin
                state_r <= DASR_IDLE;
            end
        end else if (rd && paddr == ADDR_DATA && state_r != DASR_IDLE) begin
            if (idx_r + 4'h1 >= len) begin
                state_r <= DASR_IDLE;
                idx_r   <= 4'h0;
            end else begin
                idx_r <= idx_r + 4'h1;
            end
        end
    end

    // one wait state: pready rises in the second access cycle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
            prdata  <= 32'h0000_0000;
        end else if (clk_en) begin
            pready  <= psel && penable && !pready;
            pslverr <= psel && penable && !pready && !mapped;
            prdata  <= 32'h0000_0000;
            if (psel && penable && !pready && !pwrite) begin
                if (paddr == ADDR_DATA) begin
                    prdata <= {24'h000000, byte_out};
                end else if (paddr == ADDR_STATUS) begin
                    prdata <= {24'h000000, idx_r, 2'b00, state_r};
                end else if (paddr == ADDR_ASYNC) begin
                    prdata <= {26'h0000000, async_r};
                end
            end
        end
    end

    // writes and reads take effect only at the completing edge
    logic done;
    assign done = acc && pready;

    a_summary_live: assert property (@(posedge pclk) disable iff (!presetn)
        (state_r == DASR_LAT && idx_r == 4'h1) |-> byte_out[7] == live_r[1][SUMMARY_BIT])
        else $error("latched summary bit not live");
    a_latch_holds: assert property (@(posedge pclk) disable iff (!presetn)
        (clk_en && lat_r[0][1] && !(wr && paddr == ADDR_CLEAR)) |=> lat_r[0][1])
        else $error("latched bit dropped without clear");
    a_reserved_zero: assert property (@(posedge pclk) disable iff (!presetn)
        (live_r[2][1] == 1'b0) && (live_r[2][7] == 1'b0) && (live_r[6] == 8'h00))
        else $error("reserved bit set");
    a_current_len: assert property (@(posedge pclk) disable iff (!presetn)
        (state_r == DASR_CUR) |-> idx_r < LEN_CURRENT)
        else $error("current index past nine");
    a_latched_len: assert property (@(posedge pclk) disable iff (!presetn)
        (state_r == DASR_LAT) |-> idx_r < LEN_LATCHED)
        else $error("latched index past eight");
    a_clk_lmask: assert property (@(posedge pclk) disable iff (!presetn)
        (lat_r[3][5:0] == 6'h00) && ((lat_r[7] & ~LMASK_DEC) == 8'h00))
        else $error("unlatchable bit latched");
    a_query_lat: assert property (@(posedge pclk) disable iff (!presetn)
        (state_r != DASR_LAT) ##1 (state_r == DASR_LAT)
        |-> $past(wr && paddr == ADDR_QUERY && pwdata[15:0] == OP_LATCHED))
        else $error("latched response without its query");
    a_async_dbits: assert property (@(posedge pclk) disable iff (!presetn)
        (state_r == DASR_ASY && idx_r == 4'h3) |-> byte_out == {7'h00, async_r[ASYNC_DBIT_BIT]})
        else $error("data bits byte wrong");
    a_ready_pulse: assert property (@(posedge pclk) disable iff (!presetn)
        done |=> !pready)
        else $error("pready held two cycles");

    // named steps of a register access
    sequence s_first_access;
        clk_en && psel && penable && !pready;
    endsequence
    sequence s_data_step;
        rd && paddr == ADDR_DATA && state_r != DASR_IDLE;
    endsequence
    sequence s_clear_rx;
        wr && paddr == ADDR_CLEAR && pwdata[0];
    endsequence

    a_one_wait: assert property (@(posedge pclk) disable iff (!presetn)
        s_first_access |=> pready)
        else $error("pready missing after one wait state");

    a_idle_ready: assert property (@(posedge pclk) disable iff (!presetn)
        (clk_en && !(psel && penable)) |=> !pready)
        else $error("pready without an access");

    a_err_unmapped: assert property (@(posedge pclk) disable iff (!presetn)
        (s_first_access ##0 !mapped) |=> (pready && pslverr))
        else $error("unmapped access not refused");

    a_err_mapped: assert property (@(posedge pclk) disable iff (!presetn)
        (s_first_access ##0 mapped) |=> !pslverr)
        else $error("mapped access refused");

    a_idle_data: assert property (@(posedge pclk) disable iff (!presetn)
        (s_first_access ##0 (!pwrite && paddr == ADDR_DATA && state_r == DASR_IDLE))
        |=> prdata == 32'h0000_0000)
        else $error("data read in idle not zero");

    a_step_once: assert property (@(posedge pclk) disable iff (!presetn)
        (s_data_step ##0 (idx_r + 4'h1 < len)) |=> idx_r == $past(idx_r) + 4'h1)
        else $error("data read did not step one byte");

    a_last_idle: assert property (@(posedge pclk) disable iff (!presetn)
        (s_data_step ##0 (idx_r + 4'h1 >= len)) |=> (state_r == DASR_IDLE && idx_r == 4'h0))
        else $error("response did not end after last byte");

    a_wait_nostep: assert property (@(posedge pclk) disable iff (!presetn)
        (s_first_access ##0 !pwrite) |=> idx_r == $past(idx_r))
        else $error("index stepped in wait state");

    a_freeze_state: assert property (@(posedge pclk) disable iff (!presetn)
        !clk_en |=> (state_r == $past(state_r) && idx_r == $past(idx_r)
                     && async_r == $past(async_r) && lat_r[0] == $past(lat_r[0])))
        else $error("state moved while clock enable low");

    a_query_cur: assert property (@(posedge pclk) disable iff (!presetn)
        (wr && paddr == ADDR_QUERY && pwdata[15:0] == OP_CURRENT)
        |=> (state_r == DASR_CUR && idx_r == 4'h0))
        else $error("current query not started");

    a_query_asy: assert property (@(posedge pclk) disable iff (!presetn)
        (wr && paddr == ADDR_QUERY && pwdata[15:0] == OP_ASYNC)
        |=> (state_r == DASR_ASY && idx_r == 4'h0))
        else $error("async query not started");

    a_bad_query: assert property (@(posedge pclk) disable iff (!presetn)
        (wr && paddr == ADDR_QUERY && pwdata[15:0] != OP_CURRENT
         && pwdata[15:0] != OP_LATCHED && pwdata[15:0] != OP_ASYNC)
        |=> state_r == DASR_IDLE)
        else $error("unknown query code accepted");

    a_clear_setwins: assert property (@(posedge pclk) disable iff (!presetn)
        s_clear_rx |=> lat_r[0] == ($past(live_r[0]) & lmsk[0]))
        else $error("clear did not keep active alarms");

    a_async_write: assert property (@(posedge pclk) disable iff (!presetn)
        (wr && paddr == ADDR_ASYNC) |=> async_r == $past(pwdata[5:0]))
        else $error("async config write lost");

    a_spare_latched: assert property (@(posedge pclk) disable iff (!presetn)
        (state_r == DASR_LAT && idx_r == 4'h4) |-> byte_out == 8'h00)
        else $error("latched spare byte not zero");

    a_spare_current: assert property (@(posedge pclk) disable iff (!presetn)
        (state_r == DASR_CUR && idx_r == 4'h6) |-> byte_out == 8'h00)
        else $error("current spare byte not zero");

    a_latch_sticky: assert property (@(posedge pclk) disable iff (!presetn)
        (clk_en && !(wr && paddr == ADDR_CLEAR))
        |=> ((lat_r[8] & $past(lat_r[8])) == $past(lat_r[8])))
        else $error("latched bit dropped without clear");

    a_prdata_quiet: assert property (@(posedge pclk) disable iff (!presetn)
        !pready |-> prdata == 32'h0000_0000)
        else $error("read data outside the answer cycle");
endmodule // dasr_core
`default_nettype wire

// [bench/dasr_host.sv]
`timescale 1ns/1ps
`default_nettype none
module dasr_host (
    input  wire logic        pclk,
    output logic             psel,
    output logic             penable,
    output logic             pwrite,
    output logic [7:0]       paddr,
    output logic [31:0]      pwdata,
    input  wire logic [31:0] prdata,
    input  wire logic        pready,
    input  wire logic        pslverr
);
    initial begin
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0;
    end
    // released lines carry inverted values so a stale read cannot pass
    task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
                        output logic [31:0] r, output logic e);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        r = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        paddr <= ~a;
        pwdata <= ~d;
        @(posedge pclk);
    endtask
endmodule // dasr_host
`default_nettype wire

// [bench/testbench.sv]
`timescale 1ns/1ps
`default_nettype none
module testbench;
    import dasr_pkg::*;
    logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, re;
    logic        ce = 1'b1;
    logic [7:0]  paddr;
    logic [31:0] pwdata, prdata, rv, seed;
    logic [7:0]  al [9];
    logic [7:0]  lat [9];
    logic [5:0]  acfg;
    int          error_cnt = 0;
    int          samples_checked = 0;
    int          cyc = 0;
    localparam logic [7:0] CM [9] = '{8'hff, 8'hff, 8'h7d, 8'hff, 8'h07, 8'h07, 8'h00, 8'h4d, 8'h07};
    // summary fault bit left out: it runs live, never latched
    localparam logic [7:0] LM [9] = '{8'hff, 8'h7f, 8'h7d, 8'hc0, 8'h00, 8'h07, 8'h00, 8'h44, 8'h07};
    localparam int LO [8] = '{0, 1, 2, 5, 6, 3, 7, 8};
    dasr_core dut (.pclk(pclk), .presetn(presetn), .clk_en(ce), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .receive_fault_byte_one(al[0]),
        .buffer_decoder_fault_byte(al[1]), .lock_indicator_byte(al[2]),
        .clock_activity_byte(al[3]), .insert_fault_byte(al[4]), .supply_rail_fault_byte(al[5]),
        .spare_common_byte(al[6]), .decoder_frame_fault_byte(al[7]),
        .lnb_ethernet_fault_byte(al[8]));
    dasr_host host (.pclk(pclk), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));
    initial begin
        pclk = 1'b0;
        forever #2 pclk = ~pclk;
    end
    function automatic logic [31:0] xs(input logic [31:0] x);
        x = x ^ (x << 13);
        x = x ^ (x >> 17);
        return x ^ (x << 5);
    endfunction
    function automatic logic [7:0] exp_b(input int kind, input int k);
        if (kind == 0) return al[k] & CM[k];
        if (kind == 1) return lat[LO[k]] | ((LO[k] == 1) ? (al[1] & 8'h80) : 8'h00);
        if (k == 2) return {5'h00, acfg[4:2]};
        return {7'h00, acfg[(k == 3) ? 5 : k]};
    endfunction
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp) begin
            error_cnt++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        host.xfer(1'b1, a, d, rv, re);
    endtask
    task automatic rd(input logic [7:0] a);
        host.xfer(1'b0, a, 32'h0, rv, re);
    endtask
    task automatic settle();
        // a frozen stretch first: inputs must not move the state until enabled
        ce <= 1'b0;
        repeat (2) @(posedge pclk);
        ce <= 1'b1;
        repeat (4) @(posedge pclk);
        foreach (lat[i]) lat[i] = lat[i] | (al[i] & LM[i]);
    endtask
    task automatic run_q(input logic [15:0] op, input int kind, input int n);
        wr(ADDR_QUERY, {16'h0000, op});
        rd(ADDR_STATUS);
        chk(rv, {30'h0, 2'(kind + 1)});
        for (int k = 0; k < n; k++) begin
            rd(ADDR_DATA);
            chk(rv, {24'h000000, exp_b(kind, k)});
        end
        rd(ADDR_DATA);
        chk(rv, 32'h0);
        $display("query %h done", op);
    endtask
    task automatic test_done();
        $display("checks %0d mismatches %0d", samples_checked, error_cnt);
        if (error_cnt == 0 && samples_checked > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    always @(posedge pclk) begin
        cyc <= cyc + 1;
        if (cyc == 10000) begin
            error_cnt++;
            $display("wrong value at %0t: run timed out", $time);
            test_done();
        end
    end
    initial begin
        presetn = 1'b0;
        seed = 32'h000022c2;
        acfg = 6'h38;
        foreach (al[i]) al[i] = 8'h00;
        foreach (lat[i]) lat[i] = 8'h00;
        repeat (10) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        rd(ADDR_ASYNC);
        chk(rv, {26'h0, acfg});
        rd(ADDR_DATA);
        chk(rv, 32'h0);
        rd(8'h14);
        chk({31'h0, re}, 32'h1);
        chk(rv, 32'h0);
        $display("reset and map test done");
        for (int t = 0; t < 24; t++) begin
            foreach (al[i]) begin
                seed = xs(seed);
                al[i] <= (t == 20) ? 8'hff : (t == 23) ? 8'h00 : seed[7:0];
            end
            settle();
            run_q(OP_CURRENT, 0, 9);
            run_q(OP_LATCHED, 1, 8);
            if (t % 8 == 7) begin
                seed = xs(seed);
                wr(ADDR_CLEAR, {23'h0, seed[8:0]});
                foreach (lat[i]) if (seed[i]) lat[i] = al[i] & LM[i];
            end
        end
        run_q(OP_LATCHED, 1, 8);
        wr(ADDR_QUERY, 32'h00002400);
        rd(ADDR_DATA);
        chk(rv, 32'h0);
        for (int b = 0; b < 8; b++) begin
            seed = xs(seed);
            acfg = {seed[2], b[2:0], seed[1:0]};
            wr(ADDR_ASYNC, {26'h0, acfg});
            rd(ADDR_ASYNC);
            chk(rv, {26'h0, acfg});
            run_q(OP_ASYNC, 2, 4);
        end
        test_done();
    end
endmodule // testbench
`default_nettype wire
